// [src/msp_pkg.sv]
// Package for the motion-state packet payload encoder and decoder
// Operation
// R1 - Packet 37, read, 12 bytes: acceleration X,Y,Z with gravity at 0,4,8
// R2 - Packet 38, read, 16 bytes: body accel X,Y,Z at 0,4,8, g-force at 12
// R3 - Packet 39, read, 12 bytes: roll, pitch, heading radians at 0,4,8
// R4 - Packet 40, read, 16 bytes: quaternion scalar at 0, x,y,z at 4,8,12
// R5 - Packet 41, read, 36 bytes: nine matrix floats, row-major, 0 to 32
// R6 - Packet 42, read, 12 bytes: angular velocity X,Y,Z at 0,4,8
// R7 - Packet 43, read, 12 bytes: angular acceleration X,Y,Z at 0,4,8
// R8 - Packet 44, 60 bytes: lat,lon,height doubles 0,8,16; velocity 24,28,32
// R9 - Packet 44 deviations: position at 36,40,44; velocity at 48,52,56
// R10 - Packet 45, 36 bytes: lat,lon,height doubles, deviations at 24,28,32
// R11 - Sender of packet 45 must give strictly positive position deviations
// R12 - Floats are IEEE-754 single or double, little-endian byte order
package msp_pkg;
    // Packet identifiers
    localparam logic [7:0] ID_ACCEL = 8'h25;
    localparam logic [7:0] ID_BODY_ACCEL = 8'h26;
    localparam logic [7:0] ID_EULER = 8'h27;
    localparam logic [7:0] ID_QUAT = 8'h28;
    localparam logic [7:0] ID_DCM = 8'h29;
    localparam logic [7:0] ID_ANG_VEL = 8'h2a;
    localparam logic [7:0] ID_ANG_ACC = 8'h2b;
    localparam logic [7:0] ID_EXT_POS_VEL = 8'h2c;
    localparam logic [7:0] ID_EXT_POS = 8'h2d;
    // Payload lengths in bytes
    localparam logic [7:0] LEN_12 = 8'h0c;
    localparam logic [7:0] LEN_16 = 8'h10;
    localparam logic [7:0] LEN_36 = 8'h24;
    localparam logic [7:0] LEN_60 = 8'h3c;
    // Payload buffer holds the longest payload
    localparam int MAX_LEN = 60;
    localparam logic [7:0] LEN_ZERO = 8'h00;
    localparam logic [7:0] LEN_ONE = 8'h01;
    // Packet 44 field offsets
    localparam int OFS44_LAT = 0;
    localparam int OFS44_LON = 8;
    localparam int OFS44_HGT = 16;
    localparam int OFS44_VN = 24;
    localparam int OFS44_VE = 28;
    localparam int OFS44_VD = 32;
    localparam int OFS44_SD_LAT = 36;
    localparam int OFS44_SD_LON = 40;
    localparam int OFS44_SD_HGT = 44;
    localparam int OFS44_SD_VN = 48;
    localparam int OFS44_SD_VE = 52;
    localparam int OFS44_SD_VD = 56;
    // Packet 45 field offsets
    localparam int OFS45_LAT = 0;
    localparam int OFS45_LON = 8;
    localparam int OFS45_HGT = 16;
    localparam int OFS45_SD_LAT = 24;
    localparam int OFS45_SD_LON = 28;
    localparam int OFS45_SD_HGT = 32;
    // IEEE-754 single sign bit position
    localparam int FP32_SIGN = 31;
    localparam logic [30:0] FP32_MAG_ZERO = 31'h0;

    // Outbound motion state, fp32 words
    typedef struct packed {
        logic [2:0][31:0] accel;
        logic [2:0][31:0] body_accel;
        logic [31:0] g_force;
        logic [2:0][31:0] euler;
        logic [31:0] quat_scalar;
        logic [31:0] quat_x_part;
        logic [31:0] quat_y_part;
        logic [31:0] quat_z_part;
        logic [8:0][31:0] dcm;
        logic [2:0][31:0] ang_vel;
        logic [2:0][31:0] ang_acc;
    } msp_state_t;

    // Inbound external position, decoded
    typedef struct packed {
        logic has_vel;
        logic [2:0][63:0] pos;
        logic [2:0][31:0] vel;
        logic [2:0][31:0] pos_sd;
        logic [2:0][31:0] vel_sd;
    } msp_ext_t;

    // Byte stream beat
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } msp_beat_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01
    } msp_tx_t;
endpackage

// [src/msp_framer.sv]
// Motion-state payload encoder and external position payload decoder
`timescale 1ns/1ps
module msp_framer
    import msp_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Live motion state from the navigation core
    input wire msp_state_t I_STATE,
    // Outbound request: packet id to encode
    input wire logic I_REQ_VALID,
    input wire logic [7:0] I_REQ_ID,
    output logic O_REQ_READY,
    output logic O_REQ_ERR,
    // Outbound payload byte stream
    output logic O_TX_VALID,
    output msp_beat_t O_TX_BEAT,
    input wire logic I_TX_READY,
    // Inbound payload byte stream, header already stripped
    input wire logic I_RX_START,
    input wire logic [7:0] I_RX_ID,
    input wire logic [7:0] I_RX_LEN,
    input wire logic I_RX_VALID,
    input wire msp_beat_t I_RX_BEAT,
    // Decoded inbound packet
    output logic O_EXT_VALID,
    output msp_ext_t O_EXT,
    output logic O_RX_ERR
);

    ////////////////////////////////////////////////////////////////////////
    // Encoder
    logic [MAX_LEN*8-1:0] tx_buf;
    logic [MAX_LEN*8-1:0] next_tx_buf;
    logic [7:0] tx_len;
    logic [7:0] next_tx_len;
    logic [7:0] tx_idx;
    logic id_ok;
    msp_tx_t tx_state;

    // Lay out the snapshot; little-endian packing is implicit because
    // field k occupies bits [8*ofs +: width], byte 0 in the low lane
    always_comb
    begin
        next_tx_buf = '0;
        next_tx_len = LEN_ZERO;
        id_ok = 1'b1;
        case (I_REQ_ID)
            ID_ACCEL:
            begin
                next_tx_buf[95:0] = I_STATE.accel; // R1
                next_tx_len = LEN_12;
            end
            ID_BODY_ACCEL:
            begin
                next_tx_buf[95:0] = I_STATE.body_accel; // R2
                next_tx_buf[127:96] = I_STATE.g_force; // R2
                next_tx_len = LEN_16;
            end
            ID_EULER:
            begin
                next_tx_buf[95:0] = I_STATE.euler; // R3
                next_tx_len = LEN_12;
            end
            ID_QUAT:
            begin
                next_tx_buf[31:0] = I_STATE.quat_scalar; // R4
                next_tx_buf[63:32] = I_STATE.quat_x_part; // R4
                next_tx_buf[95:64] = I_STATE.quat_y_part; // R4
                next_tx_buf[127:96] = I_STATE.quat_z_part; // R4
                next_tx_len = LEN_16;
            end
            ID_DCM:
            begin
                // Element [r][c] is index 3r+c, lowest index first
                next_tx_buf[287:0] = I_STATE.dcm; // R5
                next_tx_len = LEN_36;
            end
            ID_ANG_VEL:
            begin
                next_tx_buf[95:0] = I_STATE.ang_vel; // R6
                next_tx_len = LEN_12;
            end
            ID_ANG_ACC:
            begin
                next_tx_buf[95:0] = I_STATE.ang_acc; // R7
                next_tx_len = LEN_12;
            end
            ID_EXT_POS_VEL:
            begin
                // Read back the last accepted external fix
                next_tx_buf[191:0] = O_EXT.pos; // R8
                next_tx_buf[287:192] = O_EXT.vel; // R8
                next_tx_buf[383:288] = O_EXT.pos_sd; // R9
                next_tx_buf[479:384] = O_EXT.vel_sd; // R9
                next_tx_len = LEN_60;
            end
            ID_EXT_POS:
            begin
                next_tx_buf[191:0] = O_EXT.pos; // R10
                next_tx_buf[287:192] = O_EXT.pos_sd; // R10
                next_tx_len = LEN_36;
            end
            default:
            begin
                id_ok = 1'b0;
            end
        endcase
    end

    assign O_REQ_READY = (tx_state == TX_IDLE);
    assign O_TX_VALID = (tx_state == TX_SEND);
    assign O_TX_BEAT.data = tx_buf[7:0]; // R12
    assign O_TX_BEAT.last = (tx_idx == tx_len - LEN_ONE);

    // Snapshot taken whole at request so a packet never mixes two epochs
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            tx_state <= TX_IDLE;
            tx_buf <= '0;
            tx_len <= LEN_ZERO;
            tx_idx <= LEN_ZERO;
            O_REQ_ERR <= 1'b0;
        end
        else
        begin
            O_REQ_ERR <= 1'b0;
            case (tx_state)
                TX_IDLE:
                begin
                    if (I_REQ_VALID && id_ok)
                    begin
                        tx_buf <= next_tx_buf;
                        tx_len <= next_tx_len;
                        tx_idx <= LEN_ZERO;
                        tx_state <= TX_SEND;
                    end
                    else if (I_REQ_VALID)
                    begin
                        O_REQ_ERR <= 1'b1;
                    end
                end
                TX_SEND:
                begin
                    if (I_TX_READY)
                    begin
                        // Lowest byte leaves first
                        tx_buf <= tx_buf >> 8; // R12
                        tx_idx <= tx_idx + LEN_ONE;
                        if (O_TX_BEAT.last)
                        begin
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default:
                begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoder
    logic [MAX_LEN*8-1:0] rx_buf;
    logic [7:0] rx_cnt;
    logic rx_active;
    logic rx_len_ok;
    logic rx_is44;
    logic rx_done;
    logic sd_ok;
    msp_ext_t next_ext;

    // Only the two writable packets at their exact lengths are accepted
    assign rx_len_ok = (I_RX_ID == ID_EXT_POS_VEL && I_RX_LEN == LEN_60)
        || (I_RX_ID == ID_EXT_POS && I_RX_LEN == LEN_36);
    assign rx_done = rx_active && I_RX_VALID && I_RX_BEAT.last;

    // Collect bytes; byte n lands in lane n
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rx_active <= 1'b0;
            rx_is44 <= 1'b0;
            rx_cnt <= LEN_ZERO;
            rx_buf <= '0;
        end
        else if (I_RX_START)
        begin
            rx_active <= rx_len_ok;
            rx_is44 <= (I_RX_ID == ID_EXT_POS_VEL);
            rx_cnt <= LEN_ZERO;
            rx_buf <= '0;
        end
        else if (rx_active && I_RX_VALID)
        begin
            rx_buf[rx_cnt*8 +: 8] <= I_RX_BEAT.data; // R12
            rx_cnt <= rx_cnt + LEN_ONE;
            if (I_RX_BEAT.last)
            begin
                rx_active <= 1'b0;
            end
        end
    end

    // Field extraction uses the buffer plus the final byte in flight
    logic [MAX_LEN*8-1:0] rx_full;
    always_comb
    begin
        rx_full = rx_buf;
        rx_full[rx_cnt*8 +: 8] = I_RX_BEAT.data;
        next_ext = '0;
        next_ext.has_vel = rx_is44;
        next_ext.pos[0] = rx_full[OFS44_LAT*8 +: 64]; // R8
        next_ext.pos[1] = rx_full[OFS44_LON*8 +: 64]; // R8
        next_ext.pos[2] = rx_full[OFS44_HGT*8 +: 64]; // R8
        if (rx_is44)
        begin
            next_ext.vel[0] = rx_full[OFS44_VN*8 +: 32]; // R8
            next_ext.vel[1] = rx_full[OFS44_VE*8 +: 32]; // R8
            next_ext.vel[2] = rx_full[OFS44_VD*8 +: 32]; // R8
            next_ext.pos_sd[0] = rx_full[OFS44_SD_LAT*8 +: 32]; // R9
            next_ext.pos_sd[1] = rx_full[OFS44_SD_LON*8 +: 32]; // R9
            next_ext.pos_sd[2] = rx_full[OFS44_SD_HGT*8 +: 32]; // R9
            next_ext.vel_sd[0] = rx_full[OFS44_SD_VN*8 +: 32]; // R9
            next_ext.vel_sd[1] = rx_full[OFS44_SD_VE*8 +: 32]; // R9
            next_ext.vel_sd[2] = rx_full[OFS44_SD_VD*8 +: 32]; // R9
        end
        else
        begin
            next_ext.pos_sd[0] = rx_full[OFS45_SD_LAT*8 +: 32]; // R10
            next_ext.pos_sd[1] = rx_full[OFS45_SD_LON*8 +: 32]; // R10
            next_ext.pos_sd[2] = rx_full[OFS45_SD_HGT*8 +: 32]; // R10
        end
        // Reject sign set or magnitude zero; NaN is not screened
        sd_ok = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            if (next_ext.pos_sd[k][FP32_SIGN]
                || next_ext.pos_sd[k][30:0] == FP32_MAG_ZERO)
            begin
                sd_ok = 1'b0; // R11
            end
        end
    end

    // Publish the decoded fix; a bad length or short frame is dropped
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_EXT_VALID <= 1'b0;
            O_RX_ERR <= 1'b0;
            O_EXT <= '0;
        end
        else
        begin
            O_EXT_VALID <= 1'b0;
            O_RX_ERR <= 1'b0;
            if (I_RX_START && !rx_len_ok)
            begin
                O_RX_ERR <= 1'b1;
            end
            else if (rx_done)
            begin
                if (rx_cnt == (rx_is44 ? LEN_60 : LEN_36) - LEN_ONE
                    && sd_ok)
                begin
                    O_EXT <= next_ext;
                    O_EXT_VALID <= 1'b1;
                end
                else
                begin
                    O_RX_ERR <= 1'b1; // R11
                end
            end
        end
    end

endmodule

// [dv/msp_framer_assertions.sv]
// Port-level checker for the motion-state payload framer
`timescale 1ns/1ps
module msp_framer_assertions
    import msp_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Encoder side
    input wire logic I_REQ_VALID,
    input wire logic [7:0] I_REQ_ID,
    input wire logic O_REQ_READY,
    input wire logic O_REQ_ERR,
    input wire logic O_TX_VALID,
    input wire msp_beat_t O_TX_BEAT,
    input wire logic I_TX_READY,
    // Decoder side
    input wire logic I_RX_START,
    input wire logic [7:0] I_RX_ID,
    input wire logic [7:0] I_RX_LEN,
    input wire logic O_EXT_VALID,
    input wire msp_ext_t O_EXT,
    input wire logic O_RX_ERR
);
    logic [7:0] id;
    logic [6:0] cnt;
    logic bad;
    logic take;
    logic rx_ok;
    ////////////////////////////////////////
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // Request decode, shared by several properties
    assign bad = I_REQ_ID < 8'h25 || I_REQ_ID > 8'h2d;
    assign take = I_REQ_VALID && O_REQ_READY;
    assign rx_ok = (I_RX_ID == 8'h2c && I_RX_LEN == 8'h3c) ||
        (I_RX_ID == 8'h2d && I_RX_LEN == 8'h24);
    // Expected payload length of a packet id
    function automatic logic [6:0] plen(input logic [7:0] i);
        case (i)
            8'h26, 8'h28: return 7'h10;
            8'h29, 8'h2d: return 7'h24;
            8'h2c: return 7'h3c;
            default: return 7'h0c;
        endcase
    endfunction
    // Latch the id being sent; count bytes so the last flag can be placed
    always_ff @(posedge I_CLK or negedge I_RST_N)
        if (!I_RST_N)
            id <= 8'h00;
        else if (take)
            id <= I_REQ_ID;
    always_ff @(posedge I_CLK or negedge I_RST_N)
        if (!I_RST_N)
            cnt <= 7'h00;
        else if (O_TX_VALID && I_TX_READY)
            cnt <= O_TX_BEAT.last ? 7'h00 : cnt + 7'h01;
    AST_REQ_ERR: assert property (take && bad |=>
        O_REQ_ERR && O_REQ_READY)
        else $error("unknown id not flagged");
    AST_ERR_CAUSE: assert property (O_REQ_ERR |-> $past(take && bad))
        else $error("spurious request error");
    AST_TX_START: assert property (take && !bad |=>
        O_TX_VALID && !O_REQ_READY)
        else $error("payload did not start");
    AST_TX_HOLD: assert property (O_TX_VALID && !I_TX_READY |=>
        O_TX_VALID && $stable(O_TX_BEAT))
        else $error("byte changed while stalled");
    AST_TX_LEN: assert property (O_TX_VALID && I_TX_READY |->
        O_TX_BEAT.last == (cnt == plen(id) - 7'h01))
        else $error("last flag at wrong count");
    AST_TX_END: assert property (O_TX_VALID && I_TX_READY && O_TX_BEAT.last
        |=> !O_TX_VALID && O_REQ_READY)
        else $error("encoder did not return idle");
    AST_RX_BAD: assert property (I_RX_START && !rx_ok |=>
        O_RX_ERR && !O_EXT_VALID)
        else $error("bad frame start not refused");
    AST_EXT_HOLD: assert property (!O_EXT_VALID |-> $stable(O_EXT))
        else $error("fix changed without valid pulse");
    AST_PULSE: assert property (O_EXT_VALID |-> !O_RX_ERR ##1 !O_EXT_VALID)
        else $error("fix pulse too long");
    C_TX_DONE: cover property (O_TX_VALID && I_TX_READY && O_TX_BEAT.last);
    C_FIX44: cover property (O_EXT_VALID && O_EXT.has_vel);
    C_RX_ERR: cover property (O_RX_ERR);
endmodule
bind msp_framer msp_framer_assertions u_chk (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ_VALID(I_REQ_VALID),
    .I_REQ_ID(I_REQ_ID), .O_REQ_READY(O_REQ_READY), .O_REQ_ERR(O_REQ_ERR),
    .O_TX_VALID(O_TX_VALID), .O_TX_BEAT(O_TX_BEAT), .I_TX_READY(I_TX_READY),
    .I_RX_START(I_RX_START), .I_RX_ID(I_RX_ID), .I_RX_LEN(I_RX_LEN),
    .O_EXT_VALID(O_EXT_VALID), .O_EXT(O_EXT), .O_RX_ERR(O_RX_ERR)
);

// [dv/msp_host_model.sv]
// Host model: stalling byte sink and inbound frame source
`timescale 1ns/1ps
module msp_host_model
    import msp_pkg::*;
(
    // Clock and stall control
    input wire logic i_clk,
    input wire logic i_stall,
    // Bytes from the device
    input wire logic i_tx_valid,
    input wire msp_beat_t i_tx_beat,
    output logic o_tx_ready,
    // Frames toward the device
    output logic o_rx_start,
    output logic [7:0] o_rx_id,
    output logic [7:0] o_rx_len,
    output logic o_rx_valid,
    output msp_beat_t o_rx_beat
);
    logic [7:0] got[$];
    logic lst[$];
    ////////////////////////////////////////
    initial
    begin
        o_tx_ready = 1'b1;
        {o_rx_start, o_rx_id, o_rx_len, o_rx_valid, o_rx_beat} = '0;
    end
    // Stalls toggle ready, so each byte has to stand across cycles
    always @(posedge i_clk)
    begin
        if (i_tx_valid && o_tx_ready)
        begin
            got.push_back(i_tx_beat.data);
            lst.push_back(i_tx_beat.last);
        end
        o_tx_ready <= i_stall ? !o_tx_ready : 1'b1;
    end
    // One byte per cycle in offset order; data line flips once released
    task automatic send(input logic [7:0] id, len, input logic [7:0] b[$],
        input int la);
        @(posedge i_clk);
        o_rx_start <= 1'b1;
        o_rx_id <= id;
        o_rx_len <= len;
        foreach (b[i])
        begin
            @(posedge i_clk);
            o_rx_start <= 1'b0;
            o_rx_valid <= 1'b1;
            o_rx_beat <= '{b[i], i == la};
        end
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_beat.data <= ~b[b.size() - 1];
    endtask
endmodule

// [dv/msp_framer_tb.sv]
// Self-checking bench for the motion-state payload framer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module msp_framer_tb;
    import msp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_v = 1'b0;
    logic stall = 1'b0;
    logic [7:0] req_id = 8'h00;
    msp_state_t st;
    logic req_rdy, req_err, tx_v, tx_rdy, rx_start, rx_v, ext_v, rx_err;
    logic [7:0] rx_id, rx_len;
    msp_beat_t tx_beat, rx_beat;
    msp_ext_t ext;
    logic [7:0] fx[60] = '{default: 8'h00};
    logic [7:0] fr[$];
    int lens[9] = '{12, 16, 12, 16, 36, 12, 12, 60, 36};
    int failures = 0;
    int compares = 0;
    int oks = 0;
    int errs = 0;
    int reqerrs = 0;
    ////////////////////////////////////////
    always #2.5 clk = ~clk;
    msp_framer u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_STATE(st),
        .I_REQ_VALID(req_v), .I_REQ_ID(req_id), .O_REQ_READY(req_rdy),
        .O_REQ_ERR(req_err), .O_TX_VALID(tx_v), .O_TX_BEAT(tx_beat),
        .I_TX_READY(tx_rdy), .I_RX_START(rx_start), .I_RX_ID(rx_id),
        .I_RX_LEN(rx_len), .I_RX_VALID(rx_v), .I_RX_BEAT(rx_beat),
        .O_EXT_VALID(ext_v), .O_EXT(ext), .O_RX_ERR(rx_err));
    msp_host_model u_host (.i_clk(clk), .i_stall(stall), .i_tx_valid(tx_v),
        .i_tx_beat(tx_beat), .o_tx_ready(tx_rdy), .o_rx_start(rx_start),
        .o_rx_id(rx_id), .o_rx_len(rx_len), .o_rx_valid(rx_v),
        .o_rx_beat(rx_beat));
    // Count pulses so one-cycle answers are never missed
    always @(posedge clk)
    begin
        oks <= oks + int'(ext_v === 1'b1);
        errs <= errs + int'(rx_err === 1'b1);
        reqerrs <= reqerrs + int'(req_err === 1'b1);
    end
    // Field word k of an outbound packet, X/scalar first
    function automatic logic [31:0] w(input logic [7:0] id, input int k);
        case (id)
            8'h25: return st.accel[k];
            8'h26: return k == 3 ? st.g_force : st.body_accel[k];
            8'h27: return st.euler[k];
            8'h28: return k == 0 ? st.quat_scalar : k == 1 ? st.quat_x_part
                : k == 2 ? st.quat_y_part : st.quat_z_part;
            8'h29: return st.dcm[k];
            8'h2a: return st.ang_vel[k];
            default: return st.ang_acc[k];
        endcase
    endfunction
    task automatic req(input logic [7:0] id);
        @(posedge clk);
        req_v <= 1'b1;
        req_id <= id;
        @(posedge clk);
        req_v <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Request one packet and compare every byte, little-endian
    task automatic enc(input logic [7:0] id);
        int n;
        logic [31:0] wd;
        logic [7:0] e;
        n = lens[id - 8'h25];
        u_host.got.delete();
        u_host.lst.delete();
        req(id);
        for (int c = 0; c < 300 && u_host.got.size() < n; c++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        `CHK(u_host.got.size(), n)
        `CHK(u_host.lst[n - 1], 1'b1)
        for (int i = 0; i < n; i++)
        begin
            wd = w(id, i / 4);
            e = id < 8'h2c ? wd[8 * (i % 4) +: 8]
                : fx[(id == 8'h2d && i > 23) ? i + 12 : i];
            `CHK(u_host.got[i], e)
        end
    endtask
    task automatic mk(input int n);
        fr.delete();
        for (int i = 0; i < n; i++)
            fr.push_back(8'(i + 17));
    endtask
    // Expected fix image in packet 44 layout
    task automatic keep(input logic [7:0] id);
        foreach (fx[i])
            fx[i] = id == 8'h2c ? fr[i] : i < 24 ? fr[i]
                : (i >= 36 && i < 48) ? fr[i - 12] : 8'h00;
    endtask
    task automatic rx(input logic [7:0] id, len, input int la,
        input logic ok);
        msp_ext_t old;
        int o0;
        int e0;
        old = ext;
        o0 = oks;
        e0 = errs;
        u_host.send(id, len, fr, la);
        repeat (3) @(posedge clk);
        #1;
        `CHK(oks - o0, int'(ok))
        `CHK(errs > e0, !ok)
        if (!ok)
            `CHK(ext, old)
    endtask
    task automatic t_enc_all();
        for (int i = 0; i < 9; i++)
        begin
            stall <= i[0];
            enc(8'(37 + i));
        end
        stall <= 1'b0;
    endtask
    task automatic t_req_bad();
        int e0;
        e0 = reqerrs;
        u_host.got.delete();
        req(8'h24);
        req(8'h2e);
        `CHK(reqerrs - e0, 2)
        `CHK(u_host.got.size(), 0)
    endtask
    task automatic t_rx_good();
        mk(60);
        rx(8'h2c, 8'h3c, 59, 1'b1);
        keep(8'h2c);
        `CHK(ext.has_vel, 1'b1)
        `CHK(ext.vel_sd[2], {fr[59], fr[58], fr[57], fr[56]})
        enc(8'h2c);
        enc(8'h2d);
        mk(36);
        rx(8'h2d, 8'h24, 35, 1'b1);
        keep(8'h2d);
        `CHK(ext.has_vel, 1'b0)
        enc(8'h2c);
    endtask
    // Zero or negative deviations, wrong length or id, early last
    task automatic t_rx_bad();
        mk(36);
        for (int i = 32; i < 36; i++)
            fr[i] = 8'h00;
        rx(8'h2d, 8'h24, 35, 1'b0);
        mk(36);
        fr[27] = fr[27] | 8'h80;
        rx(8'h2d, 8'h24, 35, 1'b0);
        mk(36);
        rx(8'h2d, 8'h3c, 35, 1'b0);
        rx(8'h2b, 8'h0c, 35, 1'b0);
        rx(8'h2d, 8'h24, 30, 1'b0);
        enc(8'h2d);
    endtask
    task automatic conclude();
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        for (int i = 0; i < $bits(st) / 8; i++)
            st[i * 8 +: 8] = 8'(i * 7 + 3);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CHK(req_rdy, 1'b1)
        t_enc_all();
        t_req_bad();
        t_rx_good();
        t_rx_bad();
        conclude();
    end
    // Watchdog at 20000 cycles, well beyond the thousand or so cycles needed
    initial
    begin
        #100000;
        failures++;
        conclude();
    end
endmodule
